// File: tb/tb_lsc_ctrl.sv
// Self-checking testbench of the load switch enable control
`timescale 1ns/1ps
`include "lsc_defs.svh"
module tb_lsc_ctrl;
    import lsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset and stimulus signals
    logic clock;
    logic resetn;
    lsc_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic reg_hit;
    logic [7:0] multi_purpose_control_pin;
    lsc_boot_t boot_phase;
    logic hard_reset_mode;
    logic off_mode;
    logic [2:0] switch_one_sequence_field;
    logic [1:0] switch_one_enable_field;
    logic switch_one_pin_enable;
    logic switch_two_enable;
    logic switch_two_active_discharge;
    logic switch_two_passive_discharge;
    logic switch_two_protection_enable;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] cfg;
    logic [7:0] dsc;
    logic exp_en;

    // Device under test
    lsc_ctrl #(.PIN_COUNT(8)) lsc_ctrl_i (
        .clock(clock),
        .resetn(resetn),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .reg_hit(reg_hit),
        .multi_purpose_control_pin(multi_purpose_control_pin),
        .boot_phase(boot_phase),
        .hard_reset_mode(hard_reset_mode),
        .off_mode(off_mode),
        .switch_one_sequence_field(switch_one_sequence_field),
        .switch_one_enable_field(switch_one_enable_field),
        .switch_one_pin_enable(switch_one_pin_enable),
        .switch_two_enable(switch_two_enable),
        .switch_two_active_discharge(switch_two_active_discharge),
        .switch_two_passive_discharge(switch_two_passive_discharge),
        .switch_two_protection_enable(switch_two_protection_enable)
    );

    // 40 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_req.addr = a;
        reg_req.wdata = d;
        reg_req.write = 1'b1;
        @(negedge clock);
        reg_req.write = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(negedge clock);
        reg_req.addr = a;
        reg_req.read = 1'b1;
        @(negedge clock);
        reg_req.read = 1'b0;
        check(reg_rvalid, 8'h01, "read valid");
        check(reg_rdata, exp, "read data");
        check(reg_hit, hit, "hit flag");
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    // Expected enable of switch two from its configuration and causes
    function automatic logic exp_two(logic [7:0] c, logic [7:0] sel, logic [7:0] p, lsc_boot_t b);
        case (c[`LSC_SEQ_HI:`LSC_SEQ_LO])
            `LSC_SEQ_AT_0: return b.reached_0;
            `LSC_SEQ_AT_25: return b.reached_25;
            `LSC_SEQ_AT_50: return b.reached_50;
            `LSC_SEQ_HANDOFF: return b.reached_100 && (c[1:0] == `LSC_EN_ON || (c[1:0] == `LSC_EN_PINS && |(sel & p)));
            default: return 1'b0;
        endcase
    endfunction : exp_two

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        reg_req = '0;
        multi_purpose_control_pin = 8'h00;
        boot_phase = '0;
        hard_reset_mode = 1'b0;
        off_mode = 1'b0;
        switch_one_sequence_field = 3'h0;
        switch_one_enable_field = 2'h0;
        cyc(10);
        check(switch_two_protection_enable, 8'h00, "protection in reset");
        resetn = 1'b1;
        cyc(1);
        check(switch_two_protection_enable, 8'h01, "protection after reset");
        check(switch_two_passive_discharge, 8'h01, "passive after reset");
        // Reset values, reserved bits, unmapped offset
        rd(`LSC_OFS_SW1_PIN_SELECT, `LSC_RST_SW1_PIN_SELECT, 1'b1);
        rd(`LSC_OFS_SW2_ENABLE_CONFIG, `LSC_RST_SW2_ENABLE_CONFIG, 1'b1);
        rd(`LSC_OFS_SW2_DISCHARGE_CONFIG, `LSC_RST_SW2_DISCHARGE_CONFIG, 1'b1);
        rd(`LSC_OFS_SW2_PIN_SELECT, `LSC_RST_SW2_PIN_SELECT, 1'b1);
        wr(8'h6f, 8'hff);
        rd(8'h6f, 8'h00, 1'b0);
        wr(`LSC_OFS_SW2_ENABLE_CONFIG, 8'hff);
        rd(`LSC_OFS_SW2_ENABLE_CONFIG, 8'he3, 1'b1);
        wr(`LSC_OFS_SW2_DISCHARGE_CONFIG, 8'hfa);
        rd(`LSC_OFS_SW2_DISCHARGE_CONFIG, 8'h02, 1'b1);
        check(switch_two_protection_enable, 8'h00, "low quiescent set");
        wr(`LSC_OFS_SW1_PIN_SELECT, 8'ha5);
        rd(`LSC_OFS_SW1_PIN_SELECT, 8'ha5, 1'b1);
        wr(`LSC_OFS_SW2_PIN_SELECT, 8'h24);
        rd(`LSC_OFS_SW2_PIN_SELECT, 8'h24, 1'b1);
        $display("test registers done");
        // Every sequence, enable code and boot phase, two discharge settings
        multi_purpose_control_pin = 8'h04;
        for (int d = 0; d < 2; d++)
        begin
            dsc = (d == 0) ? 8'h05 : 8'h00;
            wr(`LSC_OFS_SW2_DISCHARGE_CONFIG, dsc);
            for (int k = 0; k < 5; k++)
            begin
                boot_phase = 4'hf >> (4 - k);
                for (int s = 0; s < 32; s++)
                begin
                    cfg = {3'(s >> 2), 3'h0, 2'(s)};
                    wr(`LSC_OFS_SW2_ENABLE_CONFIG, cfg);
                    cyc(1);
                    exp_en = exp_two(cfg, 8'h24, multi_purpose_control_pin, boot_phase);
                    check(switch_two_enable, exp_en, "switch two enable");
                    check(switch_two_active_discharge, dsc[2] & ~exp_en, "active discharge");
                    check(switch_two_passive_discharge, dsc[0] & ~exp_en, "passive discharge");
                end
            end
        end
        $display("test sequence codes done");
        // Hard reset and off entry discharge with both bits clear
        wr(`LSC_OFS_SW2_ENABLE_CONFIG, 8'h00);
        hard_reset_mode = 1'b1;
        cyc(2);
        check(switch_two_active_discharge, 8'h01, "active in hard reset");
        check(switch_two_passive_discharge, 8'h01, "passive in hard reset");
        hard_reset_mode = 1'b0;
        cyc(2);
        check(switch_two_active_discharge, 8'h00, "active after hard reset");
        off_mode = 1'b1;
        cyc(1);
        check(switch_two_passive_discharge, 8'h01, "passive on off entry");
        cyc(1);
        check(switch_two_passive_discharge, 8'h00, "passive after off entry");
        off_mode = 1'b0;
        $display("test modes done");
        // Walking pin through both selects
        boot_phase = 4'hf;
        switch_one_sequence_field = 3'h7;
        switch_one_enable_field = 2'h2;
        wr(`LSC_OFS_SW2_ENABLE_CONFIG, 8'he2);
        for (int n = 0; n < 8; n++)
        begin
            wr(`LSC_OFS_SW1_PIN_SELECT, 8'h01 << n);
            wr(`LSC_OFS_SW2_PIN_SELECT, 8'h01 << n);
            multi_purpose_control_pin = 8'h01 << n;
            cyc(3);
            check(switch_one_pin_enable, 8'h01, "switch one pin on");
            check(switch_two_enable, 8'h01, "switch two pin on");
            multi_purpose_control_pin = ~(8'h01 << n);
            cyc(3);
            check(switch_one_pin_enable, 8'h00, "switch one other pins");
            check(switch_two_enable, 8'h00, "switch two other pins");
        end
        // Several pins selected, one of them high
        wr(`LSC_OFS_SW1_PIN_SELECT, 8'h81);
        multi_purpose_control_pin = 8'h80;
        cyc(3);
        check(switch_one_pin_enable, 8'h01, "switch one or of pins");
        // Switch one fields gate its pins
        for (int s = 0; s < 32; s++)
        begin
            switch_one_sequence_field = 3'(s >> 2);
            switch_one_enable_field = 2'(s);
            cyc(2);
            check(switch_one_pin_enable, 8'(s == 30), "switch one gating");
        end
        $display("test pins done");
        results();
    end

endmodule : tb_lsc_ctrl

// File: verilog/lsc_ctrl.sv
// Enable and discharge control of load switch two, pin mask of load switch one
`timescale 1ns/1ps
`include "lsc_defs.svh"
module lsc_ctrl #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port from the serial configuration interface
    input wire lsc_pkg::lsc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,
    // Multi-purpose control pins, asynchronous
    input wire logic [PIN_COUNT-1:0] multi_purpose_control_pin,
    // Boot sequencer and power modes, same clock
    input wire lsc_pkg::lsc_boot_t boot_phase,
    input wire logic hard_reset_mode,
    input wire logic off_mode,
    // Switch one fields held elsewhere
    input wire logic [2:0] switch_one_sequence_field,
    input wire logic [1:0] switch_one_enable_field,
    // Switch one pin-derived enable
    output logic switch_one_pin_enable,
    // Switch two controls
    output logic switch_two_enable,
    output logic switch_two_active_discharge,
    output logic switch_two_passive_discharge,
    output logic switch_two_protection_enable
);
    import lsc_pkg::*;

    // Pin count check at elaboration, select registers are eight bits
    if (PIN_COUNT != 8)
    begin : g_bad_pin_count
        $error("lsc_ctrl serves exactly eight control pins");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [PIN_COUNT-1:0] pins_sync;

    lsc_sync #(
        .WIDTH(PIN_COUNT)
    ) u_pin_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in(multi_purpose_control_pin),
        .sync_out(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] sw1_sel_reg;
    logic [7:0] sw1_sel_next;
    logic [7:0] sw2_ena_reg;
    logic [7:0] sw2_ena_next;
    logic [7:0] sw2_cfg_reg;
    logic [7:0] sw2_cfg_next;
    logic [7:0] sw2_sel_reg;
    logic [7:0] sw2_sel_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit_reg;
    logic hit_next;
    logic addr_hit;

    // Write decode and read mux
    always_comb
    begin
        sw1_sel_next = sw1_sel_reg;
        sw2_ena_next = sw2_ena_reg;
        sw2_cfg_next = sw2_cfg_reg;
        sw2_sel_next = sw2_sel_reg;
        rdata_next = rdata_reg;
        addr_hit = 1'b1;
        case (reg_req.addr)
            `LSC_OFS_SW1_PIN_SELECT:
            begin
                if (reg_req.write)
                    sw1_sel_next = reg_req.wdata;
                rdata_next = sw1_sel_reg;
            end
            `LSC_OFS_SW2_ENABLE_CONFIG:
            begin
                if (reg_req.write)
                    sw2_ena_next = reg_req.wdata & `LSC_MASK_ENABLE_CONFIG;
                rdata_next = sw2_ena_reg;
            end
            `LSC_OFS_SW2_DISCHARGE_CONFIG:
            begin
                if (reg_req.write)
                    sw2_cfg_next = reg_req.wdata & `LSC_MASK_DISCHARGE_CONFIG;
                rdata_next = sw2_cfg_reg;
            end
            `LSC_OFS_SW2_PIN_SELECT:
            begin
                if (reg_req.write)
                    sw2_sel_next = reg_req.wdata;
                rdata_next = sw2_sel_reg;
            end
            default:
            begin
                addr_hit = 1'b0;
                rdata_next = 8'h00;
            end
        endcase
        if (!reg_req.read)
            rdata_next = rdata_reg;
        rvalid_next = reg_req.read;
        hit_next = (reg_req.read || reg_req.write) ? addr_hit : hit_reg;
    end

    // Register storage
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sw1_sel_reg <= `LSC_RST_SW1_PIN_SELECT;
            sw2_ena_reg <= `LSC_RST_SW2_ENABLE_CONFIG;
            sw2_cfg_reg <= `LSC_RST_SW2_DISCHARGE_CONFIG;
            sw2_sel_reg <= `LSC_RST_SW2_PIN_SELECT;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            hit_reg <= 1'b0;
        end
        else
        begin
            sw1_sel_reg <= sw1_sel_next;
            sw2_ena_reg <= sw2_ena_next;
            sw2_cfg_reg <= sw2_cfg_next;
            sw2_sel_reg <= sw2_sel_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg <= hit_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign reg_hit = hit_reg;

    ////////////////////////////////////////////////////////////////////////
    // Enable selection

    logic [2:0] sw2_seq;
    logic [1:0] sw2_en;
    logic sw1_pins_mode;
    logic sw2_pins_any;
    logic sw1_pins_any;
    lsc_src_t sw2_src;
    logic sw1_en_reg;
    logic sw1_en_next;
    logic sw2_en_reg;
    logic sw2_en_next;

    assign sw2_seq = sw2_ena_reg[`LSC_SEQ_HI:`LSC_SEQ_LO];
    assign sw2_en = sw2_ena_reg[`LSC_EN_HI:`LSC_EN_LO];
    assign sw1_pins_mode = (switch_one_sequence_field == `LSC_SEQ_HANDOFF)
        && (switch_one_enable_field == `LSC_EN_PINS);
    assign sw1_pins_any = |(pins_sync & sw1_sel_reg);
    assign sw2_pins_any = |(pins_sync & sw2_sel_reg);

    // Enable field decode, used only under the handover code
    always_comb
    begin
        case (sw2_en)
            `LSC_EN_ON: sw2_src = LSC_SRC_ON;
            `LSC_EN_PINS: sw2_src = LSC_SRC_PINS;
            default: sw2_src = LSC_SRC_OFF;
        endcase
    end

    // Next enable for both switches
    always_comb
    begin
        sw1_en_next = sw1_pins_mode && sw1_pins_any;
        case (sw2_seq)
            `LSC_SEQ_AT_0: sw2_en_next = boot_phase.reached_0;
            `LSC_SEQ_AT_25: sw2_en_next = boot_phase.reached_25;
            `LSC_SEQ_AT_50: sw2_en_next = boot_phase.reached_50;
            `LSC_SEQ_HANDOFF:
            begin
                // Field has no say until the boot delay completes
                if (!boot_phase.reached_100)
                    sw2_en_next = 1'b0;
                else
                begin
                    case (sw2_src)
                        LSC_SRC_ON: sw2_en_next = 1'b1;
                        LSC_SRC_PINS: sw2_en_next = sw2_pins_any;
                        default: sw2_en_next = 1'b0;
                    endcase
                end
            end
            default: sw2_en_next = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Discharge and protection

    logic off_mode_reg;
    logic act_dsc_next;
    logic act_dsc_reg;
    logic psv_dsc_next;
    logic psv_dsc_reg;
    logic prot_next;
    logic prot_reg;

    // Discharge requests follow the next enable so they line up with it
    always_comb
    begin
        act_dsc_next = hard_reset_mode
            || (sw2_cfg_reg[`LSC_ACT_DSC_BIT] && !sw2_en_next);
        psv_dsc_next = hard_reset_mode || (off_mode && !off_mode_reg)
            || (sw2_cfg_reg[`LSC_PSV_DSC_BIT] && !sw2_en_next);
        prot_next = !sw2_cfg_reg[`LSC_LOW_IQ_BIT];
    end

    // Output registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sw1_en_reg <= 1'b0;
            sw2_en_reg <= 1'b0;
            off_mode_reg <= 1'b0;
            act_dsc_reg <= 1'b0;
            psv_dsc_reg <= 1'b0;
            prot_reg <= 1'b0;
        end
        else
        begin
            sw1_en_reg <= sw1_en_next;
            sw2_en_reg <= sw2_en_next;
            off_mode_reg <= off_mode;
            act_dsc_reg <= act_dsc_next;
            psv_dsc_reg <= psv_dsc_next;
            prot_reg <= prot_next;
        end
    end

    assign switch_one_pin_enable = sw1_en_reg;
    assign switch_two_enable = sw2_en_reg;
    assign switch_two_active_discharge = act_dsc_reg;
    assign switch_two_passive_discharge = psv_dsc_reg;
    assign switch_two_protection_enable = prot_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    chk_sw1_pin_gate: assert property (
        !sw1_pins_mode |=> !switch_one_pin_enable)
        else $error("switch one pin enable outside pin mode");

    chk_sw1_or_follow: assert property (
        sw1_pins_mode && |(pins_sync & sw1_sel_reg) |=> switch_one_pin_enable)
        else $error("switch one missed a selected pin");

    chk_sw2_pins_or: assert property (
        sw2_seq == `LSC_SEQ_HANDOFF && sw2_en == `LSC_EN_PINS && boot_phase.reached_100
        |=> switch_two_enable == $past(|(pins_sync & sw2_sel_reg)))
        else $error("switch two does not follow selected pins");

    chk_sw2_boot_phase: assert property (
        sw2_seq == `LSC_SEQ_AT_25 |=> switch_two_enable == $past(boot_phase.reached_25))
        else $error("switch two not tied to 25 percent phase");

    chk_sw2_off_codes: assert property (
        sw2_seq inside {3'h0, 3'h1, 3'h5, 3'h6} |=> !switch_two_enable)
        else $error("switch two on under an off code");

    chk_sw2_handoff_wait: assert property (
        sw2_seq == `LSC_SEQ_HANDOFF && !boot_phase.reached_100 |=> !switch_two_enable)
        else $error("switch two on before boot delay completes");

    chk_sw2_field_on: assert property (
        sw2_seq == `LSC_SEQ_HANDOFF && sw2_en == `LSC_EN_ON && boot_phase.reached_100
        ##1 sw2_ena_reg == $past(sw2_ena_reg) |-> switch_two_enable)
        else $error("switch two not on with enable field 01");

    chk_sw2_act_dsc: assert property (
        switch_two_enable ##1 !switch_two_enable && $past(sw2_cfg_reg[`LSC_ACT_DSC_BIT])
        |-> switch_two_active_discharge)
        else $error("active discharge missing after enable fell");

    chk_sw2_prot: assert property (
        $changed(sw2_cfg_reg[`LSC_LOW_IQ_BIT])
        |=> switch_two_protection_enable == !$past(sw2_cfg_reg[`LSC_LOW_IQ_BIT]))
        else $error("protection enable does not track low quiescent bit");

    chk_sw2_psv_dsc: assert property (
        sw2_cfg_reg[`LSC_PSV_DSC_BIT] && !sw2_en_next |=> switch_two_passive_discharge)
        else $error("passive discharge missing while enable low");

endmodule : lsc_ctrl

// File: verilog/lsc_defs.svh
// Register map, field positions, reset values and codes of the load switch enable control
// Notes on behaviour
// - Switch one pin-select bit n selects pin n
// - Switch one pins count only at 111/10
// - Switch one follows OR of selected pins
// - Switch two pin-select bit n selects pin n
// - Switch two pins count only at 111/10
// - Switch two follows OR of selected pins
// - Codes 010/011/100 enable at 0/25/50 percent
// - Code 111 hands over after 100 percent
// - Enable field ignored unless sequence is 111
// - Enable field: off, on, pins, reserved
// - Active discharge: hard reset, optionally enable low
// - Low quiescent bit clear turns protection on from the first clock after reset
// - Passive discharge resets 1; hard reset, off entry, enable low
// - Switch one follows pin select at 111/10
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// Register offsets
`define LSC_OFS_SW1_PIN_SELECT 8'h6b
`define LSC_OFS_SW2_ENABLE_CONFIG 8'h6c
`define LSC_OFS_SW2_DISCHARGE_CONFIG 8'h6d
`define LSC_OFS_SW2_PIN_SELECT 8'h6e

// Reset values
`define LSC_RST_SW1_PIN_SELECT 8'h00
`define LSC_RST_SW2_ENABLE_CONFIG 8'h00
`define LSC_RST_SW2_DISCHARGE_CONFIG 8'h01
`define LSC_RST_SW2_PIN_SELECT 8'h00

// Field positions
`define LSC_SEQ_HI 7
`define LSC_SEQ_LO 5
`define LSC_EN_HI 1
`define LSC_EN_LO 0
`define LSC_ACT_DSC_BIT 2
`define LSC_LOW_IQ_BIT 1
`define LSC_PSV_DSC_BIT 0

// Writable bits of the enable and discharge configuration registers
`define LSC_MASK_ENABLE_CONFIG 8'he3
`define LSC_MASK_DISCHARGE_CONFIG 8'h07

// Sequence codes
`define LSC_SEQ_OFF 3'h0
`define LSC_SEQ_AT_0 3'h2
`define LSC_SEQ_AT_25 3'h3
`define LSC_SEQ_AT_50 3'h4
`define LSC_SEQ_HANDOFF 3'h7

// Enable field codes
`define LSC_EN_OFF 2'h0
`define LSC_EN_ON 2'h1
`define LSC_EN_PINS 2'h2

`endif

// File: verilog/lsc_pkg.sv
// Types shared by the load switch enable control
package lsc_pkg;

    // Boot/POR delay progress, levels that stay high once reached
    typedef struct packed {
        logic reached_100;
        logic reached_50;
        logic reached_25;
        logic reached_0;
    } lsc_boot_t;

    // Register access from the serial configuration port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } lsc_reg_req_t;

    // Enable source chosen for switch two
    typedef enum logic [1:0] {
        LSC_SRC_OFF,
        LSC_SRC_ON,
        LSC_SRC_PINS
    } lsc_src_t;

endpackage : lsc_pkg

// File: verilog/lsc_sync.sv
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module lsc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // Width check at elaboration
    if (WIDTH < 1)
    begin : g_bad_width
        $error("lsc_sync needs at least one bit");
    end

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_reg;
            logic stable_reg;
            // First flop read only by the second
            always_ff @(posedge clock or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule : lsc_sync
